/* boost_and_pump_enable_ctrl.sv */
// Enable and configuration register bank for the boost and charge pump.
//
// Notes on behaviour
// - Pump follows OR of selected pins.
// - Pump select bit n picks pin n.
// - Read-only boost sequence field, bits 7:5.
// - Boost software enable acts only at 111.
// - Boost pin control uses pins at 0x66.
// - Discharge on off; optionally on disable.
// - Adaptive bit raises peak current automatically.
// - Quick bit shortens startup to 50ms.
// - Switch half-size bit halves active switch.
// - Bit 7 picks table or direct peak.
// - Direct code 0 is 100mA, 25mA steps.
// - Pump software enable acts only at 111.
`timescale 1ns/10ps
`default_nettype none
module boost_and_pump_enable_ctrl
   import pmic_ctrl_pkg::*;
#(
   parameter int slow_cycles = slow_start_cycles,
   parameter int quick_cycles = quick_start_cycles
)
(
   input wire logic clk_sys_in,  // System clock.
   input wire logic rst_n_in,  // Synchronous reset, active low.
   input wire logic [2:0] boost_sequence_field_in,  // Boot-programmed boost sequence.
   input wire logic [2:0] pump_sequence_field_in,  // Boot-programmed pump sequence.
   input wire logic [2:0] boot_phase_in,  // Boot progress: 1=0%,2=25%,3=50%,4=100%.
   input wire logic off_mode_entry_in,  // Pulse on entry to Off or Hard-Reset.
   input wire logic [7:0] multipurpose_control_pin_in,  // Control pin levels.
   input wire logic [7:0] peak_table_ma_in,  // Lookup-table peak in 25mA codes.
   input wire logic reg_write_in,  // Register write strobe from the I2C core.
   input wire logic [7:0] reg_addr_in,  // Register address.
   input wire logic [7:0] reg_wdata_in,  // Write data.
   output logic [7:0] reg_rdata_out,  // Read data for the addressed register.
   output logic boost_enable_out,  // Boost regulator enable.
   output logic pump_enable_out,  // Charge pump enable.
   output logic boost_discharge_out,  // Boost passive discharge request.
   output logic boost_adaptive_peak_out,  // Adaptive peak current mode.
   output logic boost_switch_half_size_out,  // Scale switch down by half.
   output logic boost_precharge_out,  // Precharge at fixed 100mA floor.
   output logic boost_full_current_out,  // Startup ramp complete.
   output logic [9:0] boost_peak_ma_out  // Peak current setting in mA.
);

   // ******************************************************************
   // State.
   // ******************************************************************
   typedef struct packed
   {
      logic [1:0] boost_software_enable;  // Boost enable setting.
      logic [1:0] pump_software_enable;  // Pump enable setting.
      logic [3:0] boost_cfg;  // Discharge, adaptive, quick, half-size.
      logic [7:0] peak;  // Table disable and direct peak code.
      logic [7:0] pump_sel;  // Pump pin selects.
      logic [7:0] boost_pin_select_bits;  // Boost pin selects.
      logic boost_en;  // Registered boost enable.
      logic pump_en;  // Registered pump enable.
      logic discharge;  // Registered discharge request.
      logic [9:0] peak_ma;  // Registered peak current.
      logic [7:0] rdata;  // Registered read data.
   } ctrl_state_t;

   ctrl_state_t state_r;  // Registered state.
   ctrl_state_t state_nxt;  // Next state.
   logic boost_pins_or;  // OR of selected boost pins.
   logic pump_pins_or;  // OR of selected pump pins.
   logic [9:0] direct_ma;  // Direct peak setting in mA.
   logic [9:0] table_ma;  // Table peak setting in mA.
   logic boost_precharge;  // Precharge indication from the timer.

   // ******************************************************************
   // Pin selection.
   // ******************************************************************
   // boost pin select
   assign boost_pins_or = |(multipurpose_control_pin_in & state_r.boost_pin_select_bits);
   assign pump_pins_or = |(multipurpose_control_pin_in & state_r.pump_sel);

   // ******************************************************************
   // Peak current mapping.
   // ******************************************************************
   // base plus steps
   assign direct_ma = 10'(peak_base_ma) + 10'(peak_step_ma) * {6'h00, state_r.peak[3:0]};
   assign table_ma = 10'(peak_base_ma) + 10'(peak_step_ma) * {2'h0, peak_table_ma_in};

   // ******************************************************************
   // Next-state logic.
   // ******************************************************************
   // Handles writes, read data, enable decode and peak selection.
   always_comb
   begin
      state_nxt = state_r;
      // Writes touch only the writable fields of each register.
      if (reg_write_in)
      begin
         case (reg_addr_in)
            pump_enable_control_off: state_nxt.pump_software_enable = reg_wdata_in[1:0];
            pump_pin_select_off: state_nxt.pump_sel = reg_wdata_in;
            boost_enable_control_off: state_nxt.boost_software_enable = reg_wdata_in[1:0];
            boost_configuration_off: state_nxt.boost_cfg = reg_wdata_in[3:0];
            boost_peak_current_setting_off:
            begin
               state_nxt.peak = {reg_wdata_in[7], 3'h0, reg_wdata_in[3:0]};
            end
            boost_pin_select_off: state_nxt.boost_pin_select_bits = reg_wdata_in;
            default: state_nxt.pump_sel = state_r.pump_sel;
         endcase
      end
      // Read data; reserved bits read as zero.
      case (reg_addr_in)
         pump_enable_control_off:
         begin
            state_nxt.rdata = {pump_sequence_field_in, 3'h0, state_r.pump_software_enable};
         end
         pump_pin_select_off: state_nxt.rdata = state_r.pump_sel;
         boost_enable_control_off:
         begin
            state_nxt.rdata = {boost_sequence_field_in, 3'h0, state_r.boost_software_enable};
         end
         boost_configuration_off: state_nxt.rdata = {4'h0, state_r.boost_cfg};
         boost_peak_current_setting_off: state_nxt.rdata = state_r.peak;
         boost_pin_select_off: state_nxt.rdata = state_r.boost_pin_select_bits;
         default: state_nxt.rdata = 8'h00;
      endcase
      state_nxt.boost_en = regulator_enable(boost_sequence_field_in,
                                            state_r.boost_software_enable,
                                            boot_phase_in, boost_pins_or);
      state_nxt.pump_en = regulator_enable(pump_sequence_field_in,
                                           state_r.pump_software_enable,
                                           boot_phase_in, pump_pins_or & (pump_sel_width > 0));
      state_nxt.discharge = off_mode_entry_in
                            || (state_r.boost_cfg[psv_dsc_bit] && !state_nxt.boost_en);
      if (boost_precharge)
      begin
         state_nxt.peak_ma = 10'(peak_base_ma);
      end
      else if (state_r.peak[table_dis_bit])
      begin
         state_nxt.peak_ma = direct_ma;
      end
      else
      begin
         state_nxt.peak_ma = table_ma;
      end
   end

   // Registers the state with synchronous reset.
   always_ff @(posedge clk_sys_in)
   begin
      if (!rst_n_in)
      begin
         state_r <= '0;
         state_r.boost_software_enable <= en_reset;
         state_r.pump_software_enable <= en_reset;
         state_r.boost_cfg <= cfg_reset;
         state_r.peak <= peak_reset;
         state_r.pump_sel <= sel_reset;
         state_r.boost_pin_select_bits <= sel_reset;
      end
      else
      begin
         state_r <= state_nxt;
      end
   end

   // ******************************************************************
   // Startup timer.
   // ******************************************************************
   // startup time select
   boost_startup_timer #(
      .slow_cycles(slow_cycles),
      .quick_cycles(quick_cycles)
   ) startup_timer (
      .clk_sys_in(clk_sys_in),
      .rst_n_in(rst_n_in),
      .enable_in(state_r.boost_en),
      .quick_in(state_r.boost_cfg[quick_bit]),
      .precharge_out(boost_precharge),
      .full_current_out(boost_full_current_out)
   );

   // ******************************************************************
   // Outputs.
   // ******************************************************************
   assign reg_rdata_out = state_r.rdata;
   assign boost_enable_out = state_r.boost_en;
   assign pump_enable_out = state_r.pump_en;
   assign boost_discharge_out = state_r.discharge;
   assign boost_adaptive_peak_out = state_r.boost_cfg[adapt_bit];
   assign boost_switch_half_size_out = state_r.boost_cfg[half_bit];
   assign boost_precharge_out = boost_precharge;
   assign boost_peak_ma_out = state_r.peak_ma;

endmodule : boost_and_pump_enable_ctrl
`default_nettype wire

/* boost_and_pump_enable_ctrl_asserts.sv */
// Port-level checker for the boost and pump enable block, with its bind.
`timescale 1ns/10ps
`default_nettype none
module boost_and_pump_enable_ctrl_asserts
   import pmic_ctrl_pkg::*;
#(
   parameter int slow_cycles = slow_start_cycles,
   parameter int quick_cycles = quick_start_cycles
)
(
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   input wire logic [2:0] boost_sequence_field_in,
   input wire logic [2:0] pump_sequence_field_in,
   input wire logic [2:0] boot_phase_in,
   input wire logic off_mode_entry_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic [7:0] reg_rdata_out,
   input wire logic boost_enable_out,
   input wire logic pump_enable_out,
   input wire logic boost_discharge_out,
   input wire logic boost_precharge_out,
   input wire logic boost_full_current_out,
   input wire logic [9:0] boost_peak_ma_out
);
   // Counts the cycles the boost enable has stood high without a break.
   int run_cnt;
   always_ff @(posedge clk_sys_in)
   begin
      run_cnt <= (!rst_n_in || !boost_enable_out) ? 0 : run_cnt + 1;
   end
   default clocking dc @(posedge clk_sys_in); endclocking
   default disable iff (!rst_n_in);
   off_entry_a: assert property (off_mode_entry_in |=> boost_discharge_out)
      else $error("no discharge after off entry");
   boost_seq_off_a: assert property (
      (boost_sequence_field_in inside {3'h0, 3'h1, 3'h5, 3'h6}) |=> !boost_enable_out)
      else $error("boost on under off code");
   pump_seq_off_a: assert property (
      (pump_sequence_field_in inside {3'h0, 3'h1, 3'h5, 3'h6}) |=> !pump_enable_out)
      else $error("pump on under off code");
   no_phase_a: assert property (
      (boot_phase_in == 3'h0) |=> !boost_enable_out && !pump_enable_out)
      else $error("regulator on before boot start");
   early_on_a: assert property (
      (boost_sequence_field_in == 3'h2 && boot_phase_in != 3'h0) |=> boost_enable_out)
      else $error("boost off at first boot step");
   seq_read_a: assert property ((reg_addr_in == boost_enable_control_off) |=>
      reg_rdata_out[7:5] == $past(boost_sequence_field_in) && reg_rdata_out[4:2] == 3'h0)
      else $error("sequence field read wrong");
   unmapped_read_a: assert property ((reg_addr_in == 8'h00) |=> reg_rdata_out == 8'h00)
      else $error("unmapped read not zero");
   precharge_peak_a: assert property (boost_precharge_out && $past(boost_precharge_out)
      |-> boost_peak_ma_out == 10'h064) else $error("precharge peak not 100");
   idle_timer_a: assert property ((!boost_enable_out) [*3]
      |-> !boost_precharge_out && !boost_full_current_out) else $error("ramp runs while off");
   ramp_len_a: assert property (
      $rose(boost_full_current_out) |-> run_cnt >= quick_cycles - 2)
      else $error("ramp finished too early");
   cover property (boost_precharge_out);
   cover property ($rose(boost_full_current_out));
   cover property ($rose(pump_enable_out));
endmodule : boost_and_pump_enable_ctrl_asserts
bind boost_and_pump_enable_ctrl boost_and_pump_enable_ctrl_asserts #(.slow_cycles(slow_cycles),
   .quick_cycles(quick_cycles)) chk_i (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
   .boost_sequence_field_in(boost_sequence_field_in), .boot_phase_in(boot_phase_in),
   .pump_sequence_field_in(pump_sequence_field_in), .off_mode_entry_in(off_mode_entry_in),
   .reg_addr_in(reg_addr_in), .reg_rdata_out(reg_rdata_out), .boost_enable_out(boost_enable_out),
   .pump_enable_out(pump_enable_out), .boost_discharge_out(boost_discharge_out),
   .boost_precharge_out(boost_precharge_out), .boost_full_current_out(boost_full_current_out),
   .boost_peak_ma_out(boost_peak_ma_out));
`default_nettype wire

/* boost_startup_timer.sv */
// Startup ramp timer giving full-current indication for the boost.
`timescale 1ns/10ps
`default_nettype none
module boost_startup_timer
   import pmic_ctrl_pkg::*;
#(
   parameter int slow_cycles = slow_start_cycles,
   parameter int quick_cycles = quick_start_cycles
)
(
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   input wire logic enable_in,
   input wire logic quick_in,
   output logic precharge_out,
   output logic full_current_out
);

   typedef struct packed
   {
      logic [31:0] count;  // Cycles since enable.
      logic done;  // Ramp has completed.
   } timer_state_t;

   timer_state_t state_r;  // Registered state.
   timer_state_t state_nxt;  // Next state.
   logic [31:0] limit;  // Ramp length for the chosen mode.

   // ******************************************************************
   // Next-state logic.
   // ******************************************************************
   // Counts while enabled until the ramp is done, then holds; restarts whenever the enable drops.
   always_comb
   begin
      state_nxt = state_r;
      limit = quick_in ? 32'(quick_cycles) : 32'(slow_cycles);
      if (!enable_in)
      begin
         state_nxt.count = 32'h0000_0000;
         state_nxt.done = 1'b0;
      end
      else if (!state_r.done)
      begin
         if (state_r.count + 32'h0000_0001 >= limit)
         begin
            state_nxt.done = 1'b1;
         end
         state_nxt.count = state_r.count + 32'h0000_0001;
      end
   end

   // Registers the state with synchronous reset.
   always_ff @(posedge clk_sys_in)
   begin
      if (!rst_n_in)
      begin
         state_r <= '0;
      end
      else
      begin
         state_r <= state_nxt;
      end
   end

   // Slow mode precharges at the fixed floor until the ramp completes.
   assign precharge_out = enable_in && !quick_in && !state_r.done;
   assign full_current_out = state_r.done;

endmodule : boost_startup_timer
`default_nettype wire

/* pmic_ctrl_pkg.sv */
// Package with register offsets, field positions, codes and timing counts.
package pmic_ctrl_pkg;

   // ******************************************************************
   // Register offsets.
   // ******************************************************************
   localparam logic [7:0] pump_enable_control_off = 8'h5F;  // Pump sequence and enable.
   localparam logic [7:0] pump_pin_select_off = 8'h61;  // Pump control pin select.
   localparam logic [7:0] boost_enable_control_off = 8'h62;  // Boost sequence and enable.
   localparam logic [7:0] boost_configuration_off = 8'h63;  // Boost configuration.
   localparam logic [7:0] boost_peak_current_setting_off = 8'h64;  // Peak current.
   localparam logic [7:0] boost_pin_select_off = 8'h66;  // Boost control pin select.

   // ******************************************************************
   // Field positions.
   // ******************************************************************
   localparam int seq_lsb = 5;  // Sequence field lsb, bits 7:5.
   localparam int en_lsb = 0;  // Software enable lsb, bits 1:0.
   localparam int psv_dsc_bit = 3;  // Passive discharge bit.
   localparam int adapt_bit = 2;  // Adaptive peak bit.
   localparam int quick_bit = 1;  // Quick startup bit.
   localparam int half_bit = 0;  // Switch half-size bit.
   localparam int table_dis_bit = 7;  // Lookup table disable bit.
   localparam int pump_sel_width = 6;  // Only checked nonzero; pump select uses bits 7 down to 0.
   localparam int pin_count = 8;  // Number of control pins.

   // ******************************************************************
   // Reset values.
   // ******************************************************************
   localparam logic [1:0] en_reset = 2'h0;  // Software enable off.
   localparam logic [3:0] cfg_reset = 4'h0;  // Configuration cleared.
   localparam logic [7:0] peak_reset = 8'h00;  // Peak setting cleared.
   localparam logic [7:0] sel_reset = 8'h00;  // No pins selected.

   // ******************************************************************
   // Peak current mapping and timing.
   // ******************************************************************
   localparam int peak_base_ma = 100;  // Code 0 current in mA.
   localparam int peak_step_ma = 25;  // Step per code in mA.
   localparam int clk_mhz = 125;  // System clock rate.
   localparam int slow_start_ms = 100;  // Normal startup time.
   localparam int quick_start_ms = 50;  // Quick startup time.
   localparam int slow_start_cycles = slow_start_ms * 1000 * clk_mhz;
   localparam int quick_start_cycles = quick_start_ms * 1000 * clk_mhz;

   // ******************************************************************
   // Enumerations of sequence and enable codes.
   // ******************************************************************
   typedef enum logic [2:0]
   {
      seq_disabled = 3'b000,
      seq_reserved1 = 3'b001,
      seq_at_0 = 3'b010,
      seq_at_25 = 3'b011,
      seq_at_50 = 3'b100,
      seq_reserved5 = 3'b101,
      seq_reserved6 = 3'b110,
      seq_software = 3'b111
   } seq_code_t;

   typedef enum logic [1:0]
   {
      en_off = 2'b00,
      en_on = 2'b01,
      en_pins = 2'b10,
      en_reserved = 2'b11
   } en_code_t;

   // Decodes a regulator enable from sequence, software field, pins.
   function automatic logic regulator_enable(input logic [2:0] seq, input logic [1:0] en,
                                             input logic [2:0] boot_phase,
                                             input logic pins_or);
      logic result;
      result = 1'b0;
      case (seq)
         seq_at_0: result = (boot_phase >= 3'd1);
         seq_at_25: result = (boot_phase >= 3'd2);
         seq_at_50: result = (boot_phase >= 3'd3);
         seq_software:
         begin
            if (boot_phase >= 3'd4)
            begin
               case (en)
                  en_on: result = 1'b1;
                  en_pins: result = pins_or;
                  default: result = 1'b0;
               endcase
            end
         end
         default: result = 1'b0;
      endcase
      return result;
   endfunction : regulator_enable

endpackage : pmic_ctrl_pkg

/* tb_boost_and_pump_enable_ctrl.sv */
// Self-checking bench for the boost and pump enable block.
`timescale 1ns/10ps
`default_nettype none
module tb_boost_and_pump_enable_ctrl;
   import pmic_ctrl_pkg::*;
   logic clk_sys_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic [2:0] bseq = 3'h0, pseq = 3'h0, phase = 3'h0;
   logic off_entry = 1'b0, wr_en = 1'b0;
   logic [7:0] pins = 8'h00, tbl = 8'h00, addr = 8'h00, wdata = 8'h00;
   wire logic [7:0] rdata;
   wire logic b_en, p_en, dsc, adapt, half, pre, full;
   wire logic [9:0] peak_ma;
   int errors = 0;
   int checks = 0;
   // Clock at 125 MHz.
   always #4 clk_sys_in = ~clk_sys_in;
   // Short ramp counts keep the startup runs brief.
   boost_and_pump_enable_ctrl #(.slow_cycles(20), .quick_cycles(10)) DUT (
      .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .boost_sequence_field_in(bseq),
      .pump_sequence_field_in(pseq), .boot_phase_in(phase), .off_mode_entry_in(off_entry),
      .multipurpose_control_pin_in(pins), .peak_table_ma_in(tbl), .reg_write_in(wr_en),
      .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_rdata_out(rdata), .boost_enable_out(b_en),
      .pump_enable_out(p_en), .boost_discharge_out(dsc), .boost_adaptive_peak_out(adapt),
      .boost_switch_half_size_out(half), .boost_precharge_out(pre),
      .boost_full_current_out(full), .boost_peak_ma_out(peak_ma));
   task automatic chk(input logic [9:0] got, input logic [9:0] exp);
      checks++;
      if (got !== exp)
      begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // Waits n rising edges and steps just past the last one.
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys_in);
      #1;
   endtask : tick
   // One write strobe, then an idle cycle so strobes never touch.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      addr = a;
      wdata = d;
      wr_en = 1'b1;
      tick(1);
      wr_en = 1'b0;
      tick(1);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      addr = a;
      tick(1);
      chk(rdata, exp);
   endtask : rd
   // Expected enable from sequence code, boot step, software code and pins.
   function automatic logic want(input int s, input int p, input int e, input logic po);
      return (s == 2 && p >= 1) || (s == 3 && p >= 2) || (s == 4 && p >= 3) ||
         (s == 7 && p >= 4 && (e == 1 || (e == 2 && po)));
   endfunction : want
   task automatic t_regs();
      bseq = 3'h5;
      pseq = 3'h3;
      rd(boost_enable_control_off, 8'hA0);
      rd(pump_enable_control_off, 8'h60);
      rd(8'h00, 8'h00);
      wr(boost_enable_control_off, 8'hFF);
      rd(boost_enable_control_off, 8'hA3);
      wr(pump_enable_control_off, 8'hFF);
      rd(pump_enable_control_off, 8'h63);
      wr(boost_configuration_off, 8'hFF);
      rd(boost_configuration_off, 8'h0F);
      wr(boost_peak_current_setting_off, 8'hFF);
      rd(boost_peak_current_setting_off, 8'h8F);
      wr(boost_pin_select_off, 8'hA5);
      rd(boost_pin_select_off, 8'hA5);
      wr(pump_pin_select_off, 8'h5A);
      rd(pump_pin_select_off, 8'h5A);
      wr(8'h70, 8'hFF);
      rd(8'h70, 8'h00);
   endtask : t_regs
   // Every sequence code, boot step and software code for both regulators.
   task automatic t_seq();
      wr(boost_pin_select_off, 8'hFF);
      wr(pump_pin_select_off, 8'hFF);
      pins = 8'hFF;
      for (int s = 0; s < 8; s++)
         for (int p = 0; p < 5; p++)
            for (int e = 0; e < 4; e++)
            begin
               bseq = s[2:0];
               pseq = s[2:0];
               phase = p[2:0];
               wr(boost_enable_control_off, {6'h00, e[1:0]});
               wr(pump_enable_control_off, {6'h00, e[1:0]});
               tick(1);
               chk(b_en, want(s, p, e, 1'b1));
               chk(p_en, want(s, p, e, 1'b1));
            end
   endtask : t_seq
   // Each pin alone selected, driven high and then with all others high.
   task automatic t_pins();
      wr(boost_enable_control_off, 8'h02);
      wr(pump_enable_control_off, 8'h02);
      for (int n = 0; n < 8; n++)
      begin
         wr(boost_pin_select_off, 8'h01 << n);
         wr(pump_pin_select_off, 8'h01 << n);
         pins = 8'h01 << n;
         tick(2);
         chk(b_en, 1'b1);
         chk(p_en, 1'b1);
         pins = ~(8'h01 << n);
         tick(2);
         chk(b_en, 1'b0);
         chk(p_en, 1'b0);
      end
   endtask : t_pins
   task automatic t_cfg();
      wr(boost_enable_control_off, 8'h00);
      wr(boost_configuration_off, 8'h05);
      tick(1);
      chk({dsc, adapt, half}, 3'h3);
      wr(boost_configuration_off, 8'h0A);
      tick(1);
      chk({dsc, adapt, half}, 3'h4);
      tbl = 8'h03;
      for (int c = 0; c < 16; c++)
      begin
         wr(boost_peak_current_setting_off, 8'h80 | c[7:0]);
         chk(peak_ma, 10'h064 + 10'h019 * c[9:0]);
      end
      wr(boost_peak_current_setting_off, 8'h0F);
      chk(peak_ma, 10'h0AF);
      wr(boost_enable_control_off, 8'h01);
      tick(1);
      chk(dsc, 1'b0);
      off_entry = 1'b1;
      tick(1);
      off_entry = 1'b0;
      chk(dsc, 1'b1);
   endtask : t_cfg
   // Startup ramp length and precharge floor for one setting of the quick bit.
   task automatic t_start(input logic [7:0] cfg, input int span);
      int n;
      n = 0;
      wr(boost_enable_control_off, 8'h00);
      wr(boost_configuration_off, cfg);
      tick(2);
      chk(full, 1'b0);
      wr(boost_enable_control_off, 8'h01);
      while (full !== 1'b1 && n < 200)
      begin
         if (n == 3)
         begin
            chk(pre, !cfg[1]);
            chk(peak_ma, cfg[1] ? 10'h0AF : 10'h064);
         end
         tick(1);
         n++;
      end
      chk(n >= span - 4 && n <= span + 4, 1'b1);
   endtask : t_start
   task automatic close_out();
      $display("mismatches %0d comparisons %0d", errors, checks);
      if (errors == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : close_out
   initial
   begin
      repeat (10) @(posedge clk_sys_in);
      #1;
      rst_n_in = 1'b1;
      tick(1);
      t_regs();
      t_seq();
      t_pins();
      t_cfg();
      t_start(8'h00, 20);
      t_start(8'h02, 10);
      close_out();
   end
   // Cuts a hang short well beyond the roughly one thousand cycles the tests need.
   initial
   begin
      #240000;
      errors++;
      close_out();
   end
endmodule : tb_boost_and_pump_enable_ctrl
`default_nettype wire
